// >>> rtl/upm_regs.svh
// register map, field positions and role codes of the uart pin mux
`ifndef UPM_REGS_SVH
`define UPM_REGS_SVH
`define UPM_ADDR_W 4
`define UPM_DATA_W 32
`define UPM_ADDR_SEL 4'h0
`define UPM_ADDR_GP_OUT 4'h4
`define UPM_ADDR_GP_OE 4'h8
`define UPM_ADDR_STAT 4'hc
`define UPM_SEL_W 3
`define UPM_SEL_P2 0
`define UPM_SEL_P3 3
`define UPM_SEL_P4 6
`define UPM_SEL_P5 9
`define UPM_SEL_P6 12
`define UPM_SEL_P7 15
`define UPM_SEL_MAIN 3'h0
`define UPM_SEL_GP 3'h1
`define UPM_SEL_GIO 3'h2
`define UPM_SEL_WAKE 3'h3
`define UPM_SEL_RS485 3'h4
`define UPM_PIN_LO 2
`define UPM_PIN_HI 7
`define UPM_NPIN 6
`endif

// >>> rtl/upm_pkg.sv
// types shared by the uart pin mux
package upm_pkg;
   typedef enum logic [1:0] {UPM_ST_LOAD, UPM_ST_RUN} upm_state_e;
   typedef struct packed {
      logic [5:0] pin_out;
      logic [5:0] pin_oe;
   } upm_pins_s;
   typedef struct packed {
      logic rts_n;
      logic dtr_n;
      logic tx;
      logic rs485_de;
   } upm_uart_out_s;
   typedef struct packed {
      logic rx;
      logic cts_n;
      logic dsr_n;
      logic wake_n;
   } upm_uart_in_s;
endpackage

// >>> rtl/upm_pin_mux.sv
// pin role selection for the uart-side pins and the power-limit flag
// Notes on behaviour
// - pin 6 resets to serial receive
// - pin 7 resets to serial transmit
// - pin 5: gpio, request-to-send, rs485 enable
// - pin 4: gpio or clear-to-send input
// - pins 2,3: gpio, data-set-ready, terminal-ready
// - power flag asserted unless full current permitted
// - flag asserted while suspended or unconfigured
// - flag active low, polarity from otp
`timescale 1ns/10ps
`include "upm_regs.svh"
module upm_pin_mux (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [`UPM_ADDR_W-1:0] i_addr,
   input wire logic [`UPM_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [`UPM_DATA_W-1:0] o_rdata,
   input wire logic i_cdc_acm,
   input wire logic i_suspended,
   input wire logic i_configured,
   input wire logic i_otp_valid,
   input wire logic i_otp_pwr_inv,
   input wire upm_pkg::upm_uart_out_s i_uart,
   output upm_pkg::upm_uart_in_s o_uart,
   input wire logic [5:0] i_pin,
   output upm_pkg::upm_pins_s o_pins,
   output logic o_power_limit_out,
   output logic o_power_limit_oe
);
   // one register image: sync stages, mux setup and registered outputs
   typedef struct packed {
      upm_pkg::upm_state_e st;
      // six 3-bit role codes, pin 2 in the lowest field
      logic [17:0] sel;
      logic [5:0] gp_out;
      logic [5:0] gp_oe;
      // two-stage synchronisers; only the second stage feeds logic
      logic [5:0] pin_m;
      logic [5:0] pin_s;
      logic [3:0] stat_m;
      logic [3:0] stat_s;
      logic acm_m;
      logic acm_s;
      // flag polarity, frozen when otp is loaded
      logic inv;
      logic [`UPM_DATA_W-1:0] rdata;
      upm_pkg::upm_pins_s pins;
      upm_pkg::upm_uart_in_s uin;
      logic pwr;
      logic pwr_oe;
   } upm_state_s;

   upm_state_s s_q, s_d;

   // reset role codes; the class strap only matters for pins 4 and 5
   // the strap is taken once at load, a later change needs a new reset
   function automatic logic [17:0] reset_sel(input logic acm);
      logic [17:0] v;
      v = '0;
      v[`UPM_SEL_P2 +: `UPM_SEL_W] = `UPM_SEL_GIO;
      v[`UPM_SEL_P3 +: `UPM_SEL_W] = `UPM_SEL_GIO;
      v[`UPM_SEL_P4 +: `UPM_SEL_W] = acm ? `UPM_SEL_MAIN : `UPM_SEL_GIO;
      v[`UPM_SEL_P5 +: `UPM_SEL_W] = acm ? `UPM_SEL_MAIN : `UPM_SEL_GIO;
      v[`UPM_SEL_P6 +: `UPM_SEL_W] = `UPM_SEL_MAIN;
      v[`UPM_SEL_P7 +: `UPM_SEL_W] = `UPM_SEL_MAIN;
      return v;
   endfunction

   // role code of one pin; index 0 is pin 2
   function automatic logic [2:0] sel_of(input logic [17:0] v, input int idx);
      return v[idx*`UPM_SEL_W +: `UPM_SEL_W];
   endfunction

   // gpio and enhanced io both hand the pin to the software registers
   function automatic logic is_soft_role(input logic [2:0] code);
      return code == `UPM_SEL_GP || code == `UPM_SEL_GIO;
   endfunction

   // address match shared by the write and the read decoder
   function automatic logic hit(input logic stb, input logic [`UPM_ADDR_W-1:0] a,
                                input logic [`UPM_ADDR_W-1:0] target);
      return stb && a == target;
   endfunction

   always_comb begin
      logic [2:0] c;
      logic unsafe;
      c = '0;
      unsafe = 1'b0;
      s_d = s_q;

      // pins, status lines and the class strap are all asynchronous
      s_d.pin_m = i_pin;
      s_d.pin_s = s_q.pin_m;
      s_d.stat_m = {i_suspended, i_configured, i_otp_valid, i_otp_pwr_inv};
      s_d.stat_s = s_q.stat_m;
      s_d.acm_m = i_cdc_acm;
      s_d.acm_s = s_q.acm_m;

      // writes are refused until the load state has finished
      case (s_q.st)
         upm_pkg::UPM_ST_LOAD: begin
            // wait for otp so the flag never shows a wrong level
            if (s_q.stat_s[1]) begin
               s_d.inv = s_q.stat_s[0];
               s_d.sel = reset_sel(s_q.acm_s);
               s_d.st = upm_pkg::UPM_ST_RUN;
            end
         end
         default: begin
            if (hit(i_wr, i_addr, `UPM_ADDR_SEL)) begin
               s_d.sel = i_wdata[17:0];
            end else if (hit(i_wr, i_addr, `UPM_ADDR_GP_OUT)) begin
               s_d.gp_out = i_wdata[5:0];
            end else if (hit(i_wr, i_addr, `UPM_ADDR_GP_OE)) begin
               s_d.gp_oe = i_wdata[5:0];
            end
         end
      endcase

      // read data stand for one cycle, zero otherwise and for unmapped offsets
      s_d.rdata = '0;
      if (hit(i_rd, i_addr, `UPM_ADDR_SEL)) begin
         s_d.rdata = {14'h0, s_q.sel};
      end else if (hit(i_rd, i_addr, `UPM_ADDR_GP_OUT)) begin
         s_d.rdata = {26'h0, s_q.gp_out};
      end else if (hit(i_rd, i_addr, `UPM_ADDR_GP_OE)) begin
         s_d.rdata = {26'h0, s_q.gp_oe};
      end else if (hit(i_rd, i_addr, `UPM_ADDR_STAT)) begin
         s_d.rdata = {18'h0, s_q.pin_s, s_q.pwr, s_q.inv, s_q.stat_s, 1'b0,
                      s_q.st == upm_pkg::UPM_ST_RUN};
      end

      // pins idle as inputs; only output roles and gpio enables drive
      s_d.pins.pin_oe = '0;
      s_d.pins.pin_out = '0;
      if (s_q.st == upm_pkg::UPM_ST_RUN) begin
         for (int i = 0; i < `UPM_NPIN; i++) begin
            c = sel_of(s_q.sel, i);
            if (is_soft_role(c)) begin
               s_d.pins.pin_oe[i] = s_q.gp_oe[i];
               s_d.pins.pin_out[i] = s_q.gp_out[i];
            end
         end
         // pin 3 carries terminal-ready out of the serial engine
         if (sel_of(s_q.sel, 1) == `UPM_SEL_MAIN) begin
            s_d.pins.pin_oe[1] = 1'b1;
            s_d.pins.pin_out[1] = i_uart.dtr_n;
         end
         // pin 5: request-to-send, or the half-duplex driver enable
         // the enable timing itself belongs to the serial engine
         if (sel_of(s_q.sel, 3) == `UPM_SEL_MAIN) begin
            s_d.pins.pin_oe[3] = 1'b1;
            s_d.pins.pin_out[3] = i_uart.rts_n;
         end else if (sel_of(s_q.sel, 3) == `UPM_SEL_RS485) begin
            s_d.pins.pin_oe[3] = 1'b1;
            s_d.pins.pin_out[3] = i_uart.rs485_de;
         end
         // pin 7 transmit data
         if (sel_of(s_q.sel, 5) == `UPM_SEL_MAIN) begin
            s_d.pins.pin_oe[5] = 1'b1;
            s_d.pins.pin_out[5] = i_uart.tx;
         end
      end

      // rx and wake_n idle high (inactive), cts_n and dsr_n idle low (asserted) when the pin has another role
      if (sel_of(s_q.sel, 4) == `UPM_SEL_MAIN) begin
         s_d.uin.rx = s_q.pin_s[4];
      end else begin
         s_d.uin.rx = 1'b1;
      end
      if (sel_of(s_q.sel, 4) == `UPM_SEL_WAKE) begin
         s_d.uin.wake_n = s_q.pin_s[4];
      end else begin
         s_d.uin.wake_n = 1'b1;
      end
      if (sel_of(s_q.sel, 2) == `UPM_SEL_MAIN) begin
         s_d.uin.cts_n = s_q.pin_s[2];
      end else begin
         s_d.uin.cts_n = 1'b0;
      end
      if (sel_of(s_q.sel, 0) == `UPM_SEL_MAIN) begin
         s_d.uin.dsr_n = s_q.pin_s[0];
      end else begin
         s_d.uin.dsr_n = 1'b0;
      end

      // unsafe to draw full current while suspended or not configured
      unsafe = s_q.stat_s[3] || !s_q.stat_s[2];
      // inv low gives an active-low flag; the driver waits for the load
      if (unsafe) begin
         s_d.pwr = s_q.inv;
      end else begin
         s_d.pwr = !s_q.inv;
      end
      s_d.pwr_oe = s_q.st == upm_pkg::UPM_ST_RUN;
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;
   assign o_pins = s_q.pins;
   assign o_uart = s_q.uin;
   assign o_power_limit_out = s_q.pwr;
   assign o_power_limit_oe = s_q.pwr_oe;
endmodule

// >>> verification/upm_monitor.sv
// port assertions for the uart pin mux
`timescale 1ns/10ps
module upm_monitor (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic i_cdc_acm,
   input wire logic i_suspended,
   input wire logic i_configured,
   input wire logic i_otp_pwr_inv,
   input wire upm_pkg::upm_pins_s o_pins,
   input wire logic o_power_limit_out,
   input wire logic o_power_limit_oe
);
   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   a_rdata_idle: assert property (!i_rd |=> o_rdata == '0)
      else $error("read data outside its slot");
   a_flag_susp: assert property ((i_suspended && !i_otp_pwr_inv)[*5]
      ##0 o_power_limit_oe |-> !o_power_limit_out) else $error("flag not set in suspend");
   a_flag_unconf: assert property ((!i_configured && !i_otp_pwr_inv)[*5]
      ##0 o_power_limit_oe |-> !o_power_limit_out) else $error("flag not set unconfigured");
   a_flag_safe: assert property ((i_configured && !i_suspended && !i_otp_pwr_inv)[*5]
      ##0 o_power_limit_oe |-> o_power_limit_out) else $error("flag set while safe");
   a_flag_inverted: assert property ((i_suspended && i_otp_pwr_inv)[*5]
      ##0 o_power_limit_oe |-> o_power_limit_out) else $error("inverted flag wrong");
   a_oe_hold: assert property (o_power_limit_oe |=> o_power_limit_oe)
      else $error("flag driver dropped");
   a_pins_quiet: assert property (!o_power_limit_oe |-> o_pins.pin_oe == '0)
      else $error("pin driven before load");
   a_reset_roles: assert property ($rose(o_power_limit_oe) |-> o_pins.pin_oe[5]
      && o_pins.pin_oe[3:0] == {i_cdc_acm, 3'h0} && !o_pins.pin_oe[4])
      else $error("wrong default pin roles");
   c_load: cover property ($rose(o_power_limit_oe));
   c_read: cover property (i_rd ##1 o_rdata != '0);
   c_flag_high: cover property (o_power_limit_oe && o_power_limit_out);
endmodule
bind upm_pin_mux upm_monitor u_mon (.*);

// >>> verification/upm_far_side.sv
// serial peripheral: drives every pin line the mux leaves undriven
`timescale 1ns/10ps
module upm_far_side (
   input wire upm_pkg::upm_pins_s i_pins,
   input wire logic [5:0] i_drive,
   output logic [5:0] o_level
);
   assign o_level = (i_pins.pin_oe & i_pins.pin_out) | (~i_pins.pin_oe & i_drive);
endmodule

// >>> verification/upm_tb.sv
// self-checking bench for the uart pin mux
`timescale 1ns/10ps
module testbench;
   logic i_core_clk, i_rst, i_wr, i_rd, i_cdc_acm, i_suspended, i_configured;
   logic i_otp_valid, i_otp_pwr_inv, o_power_limit_out, o_power_limit_oe;
   logic [3:0] i_addr;
   logic [31:0] i_wdata, o_rdata;
   logic [5:0] drive, level;
   upm_pkg::upm_uart_out_s i_uart;
   upm_pkg::upm_uart_in_s o_uart;
   upm_pkg::upm_pins_s o_pins;
   int fails, checked;
   upm_pin_mux dut (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_cdc_acm, .i_suspended, .i_configured, .i_otp_valid, .i_otp_pwr_inv, .i_uart,
      .o_uart, .i_pin(level), .o_pins, .o_power_limit_out, .o_power_limit_oe);
   upm_far_side far (.i_pins(o_pins), .i_drive(drive), .o_level(level));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, exp);
   endtask
   // reset, then wait a bounded time for the otp load to finish
   task automatic boot(input logic acm, input logic inv);
      i_rst <= 1'b1;
      i_otp_valid <= 1'b0;
      i_cdc_acm <= acm;
      i_otp_pwr_inv <= inv;
      tick(2);
      i_rst <= 1'b0;
      i_otp_valid <= 1'b1;
      for (int k = 0; k < 20 && o_power_limit_oe !== 1'b1; k++) tick(1);
      chk(o_power_limit_oe, 1'b1);
      if (o_power_limit_oe !== 1'b1) end_of_test();
   endtask
   initial begin
      i_core_clk = 1'b0;
      forever #12.5 i_core_clk = ~i_core_clk;
   end
   initial begin
      {i_addr, i_wdata, i_wr, i_rd, i_suspended, i_configured} = '0;
      {fails, checked} = '0;
      i_uart = 4'h3;
      drive = 6'h04;
      boot(1'b0, 1'b0);
      rd(4'h0, 32'h492);
      chk(o_pins.pin_oe, 6'h20);
      chk(o_pins.pin_out[5], 1'b1);
      chk({o_uart.rx, o_uart.cts_n}, 2'h0);
      chk(o_power_limit_out, 1'b0);
      i_configured <= 1'b1;
      tick(4);
      chk(o_power_limit_out, 1'b1);
      i_suspended <= 1'b1;
      tick(4);
      chk(o_power_limit_out, 1'b0);
      rd(4'h2, 32'h0);
      wr(4'h0, 32'h812);
      wr(4'h4, 32'h1);
      wr(4'h8, 32'h1);
      tick(4);
      chk(o_pins.pin_oe, 6'h29);
      chk(o_pins.pin_out & 6'h29, 6'h29);
      chk(o_uart.cts_n, 1'b1);
      wr(4'h0, 32'h3800);
      tick(4);
      chk(o_pins.pin_oe, 6'h2a);
      chk(o_pins.pin_out & 6'h2a, 6'h28);
      chk({o_uart.rx, o_uart.wake_n, o_uart.dsr_n, o_uart.cts_n}, 4'h9);
      rd(4'hc, 32'h2c39);
      // second reset mid-run swaps the class mode and the flag polarity
      boot(1'b1, 1'b1);
      rd(4'h0, 32'h12);
      chk(o_pins.pin_oe, 6'h28);
      chk(o_power_limit_out, 1'b1);
      i_suspended <= 1'b0;
      tick(4);
      chk(o_power_limit_out, 1'b0);
      end_of_test();
   end
endmodule
